// ===== common/acs_pkg.sv
// constants and types for the eight-input converter channel sequencer
// assumes a single 25 MHz clock domain and word-aligned register offsets
`default_nettype none

package acs_pkg;
	// ==========================================
	// serial frame
	localparam int FRAME_BITS = 16;
	localparam logic [4:0] CTL_LAST_FALL = 5'h0b;
	localparam logic [4:0] MASK_LAST_FALL = 5'h0f;
	localparam logic [4:0] FRAME_END = 5'h10;
	// ==========================================
	// control word fields, first received bit is bit 11
	localparam int WR_EN_BIT = 11;
	localparam int AUTO_CYC_BIT = 10;
	localparam int CHAN_ADDR_MSB = 9;
	localparam int CHAN_ADDR_LSB = 7;
	localparam int MASK_SEL_BIT = 4;
	localparam int RANGE_BIT = 1;
	localparam int CODING_BIT = 0;
	localparam logic [11:0] CTL_RESET = 12'h000;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	// ==========================================
	// register map
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_MASK = 8'h08;
	localparam logic [7:0] ADDR_CFG = 8'h0c;
	localparam int CFG_EN_BIT = 0;
	localparam logic CFG_EN_RESET = 1'h1;
	localparam int ST_CHAN_LSB = 0;
	localparam int ST_POS_LSB = 3;
	localparam int ST_MODE_LSB = 7;
	localparam int ST_ARMED_BIT = 9;
	localparam int ST_LOADED_BIT = 10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================
	// channel selection modes
	typedef enum logic [1:0] {
		MODE_DIRECT,
		MODE_MASK,
		MODE_CONSEC
	} acs_mode_t;
endpackage

`default_nettype wire

// ===== rtl/acs_top.sv
// serial-side channel selection, sequencing and result word formatting
// assumes asynchronous cs_n/sclk/din pins and a front end that converts on conv_start
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - direct mode converts the channel named by the control address field
// - result coded straight binary or two's complement by control bit 0
// - range bit drives the span select output to the analog front end
// - output word is a zero, three channel bits, twelve result bits
// - channel bits name conv_chan when the result is taken, the input converted unless a later frame has started
// - after mask load, lowest selected channel first, then next higher each frame
// - mask sequence steps ascending on every frame without further writes
// - control write with sequencer bits 1,0 leaves the sequence running
// - control write with any other sequencer bits ends the sequence
// - after the last selected channel the mask sequence wraps to the first
// - sequencer bits 1,1 start consecutive run from channel 0 to address field
// - consecutive run restarts at channel 0 after the final channel
// - frame after a 0,1 write loads the 16-bit mask on sclk falls
// - first mask byte is sequence one, second sequence two, run in that order
// - control taken from first 12 bits only when received write bit is 1
module acs_top #(
	parameter int FIFO_DEPTH = 2,
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// serial pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	// analog front end
	output logic conv_start,
	output logic [2:0] conv_chan,
	output logic range_span_ref,
	input wire logic conv_valid,
	input wire logic [11:0] conv_data,
	output logic conv_ready,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

	// ==========================================
	// helpers
	// next set mask position after p, searching circularly; index i is mask[15-i]
	function automatic logic [3:0] mask_next(input logic [15:0] m, input logic [3:0] p);
		logic [3:0] idx;
		logic [3:0] res;
		logic found;
		res = p;
		found = 1'h0;
		for (int i = 1; i <= 16; i++) begin
			idx = p + 4'(i);
			if (!found && m[4'hf - idx]) begin
				res = idx;
				found = 1'h1;
			end
		end
		return res;
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return a == ADDR_W'(acs_pkg::ADDR_STATUS) || a == ADDR_W'(acs_pkg::ADDR_CTRL) ||
			a == ADDR_W'(acs_pkg::ADDR_MASK) || a == ADDR_W'(acs_pkg::ADDR_CFG);
	endfunction

	// ==========================================
	// pin synchronisers
	logic [2:0] cs_sync;
	logic [2:0] sclk_sync;
	logic [1:0] din_sync;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cs_sync <= 3'h7;
			sclk_sync <= 3'h7;
			din_sync <= 2'h0;
		end else begin
			cs_sync <= {cs_sync[1:0], cs_n};
			sclk_sync <= {sclk_sync[1:0], sclk};
			din_sync <= {din_sync[0], din};
		end
	end

	logic serial_en;
	logic frame, cs_fall, sclk_fall, ctl_done, mask_done;
	logic [4:0] bit_cnt;
	logic [15:0] rx_sh, rx_next;
	assign frame = serial_en & ~cs_sync[1];
	assign cs_fall = serial_en & cs_sync[2] & ~cs_sync[1];
	assign sclk_fall = frame & sclk_sync[2] & ~sclk_sync[1];
	assign rx_next = {rx_sh[14:0], din_sync[1]};
	assign ctl_done = sclk_fall && bit_cnt == acs_pkg::CTL_LAST_FALL;
	assign mask_done = sclk_fall && bit_cnt == acs_pkg::MASK_LAST_FALL;

	// ==========================================
	// result buffer
	logic [15:0] mem [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [PTR_W:0] cnt, next_cnt;
	logic next_conv_ready, push, pop, coding_q, tx_loaded;
	logic [15:0] push_word;
	assign push = conv_valid & conv_ready;
	assign pop = frame & ~cs_fall & ~tx_loaded & (cnt != '0);
	assign push_word = {1'h0, conv_chan,
		coding_q ? conv_data : {~conv_data[11], conv_data[10:0]}};

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_cnt = cnt;
		if (push) begin
			next_wr_ptr = (wr_ptr == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + 1'h1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + 1'h1;
		end
		if (push && !pop) begin
			next_cnt = cnt + 1'h1;
		end else if (pop && !push) begin
			next_cnt = cnt - 1'h1;
		end
		next_conv_ready = next_cnt < (PTR_W + 1)'(FIFO_DEPTH);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			cnt <= '0;
			conv_ready <= 1'h0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			cnt <= next_cnt;
			conv_ready <= next_conv_ready;
		end
	end

	always_ff @(posedge aclk) begin
		if (push) begin
			mem[wr_ptr] <= push_word;
		end
	end

	// ==========================================
	// serial shifter
	logic [15:0] tx_word, next_tx_word, next_rx_sh;
	logic [4:0] next_bit_cnt;
	logic [3:0] idx;
	logic next_tx_loaded, next_dout, next_dout_oe;
	always_comb begin
		next_bit_cnt = bit_cnt;
		next_rx_sh = rx_sh;
		next_tx_word = tx_word;
		next_tx_loaded = tx_loaded;
		if (cs_fall) begin
			next_bit_cnt = 5'h00;
			next_tx_loaded = 1'h0;
		end else if (sclk_fall && bit_cnt != acs_pkg::FRAME_END) begin
			next_bit_cnt = bit_cnt + 5'h01;
			next_rx_sh = rx_next;
		end
		if (pop) begin
			next_tx_word = mem[rd_ptr];
			next_tx_loaded = 1'h1;
		end
		idx = 4'hf - next_bit_cnt[3:0];
		next_dout = frame && next_tx_loaded && next_bit_cnt < 5'(acs_pkg::FRAME_BITS) &&
			next_tx_word[idx];
		next_dout_oe = frame;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bit_cnt <= acs_pkg::FRAME_END;
			rx_sh <= 16'h0000;
			tx_word <= 16'h0000;
			tx_loaded <= 1'h0;
			dout <= 1'h0;
			dout_oe <= 1'h0;
		end else begin
			bit_cnt <= next_bit_cnt;
			rx_sh <= next_rx_sh;
			tx_word <= next_tx_word;
			tx_loaded <= next_tx_loaded;
			dout <= next_dout;
			dout_oe <= next_dout_oe;
		end
	end

	// ==========================================
	// sequencer
	logic [11:0] ctl, next_ctl;
	logic [15:0] mask, next_mask;
	logic [3:0] pos, next_pos;
	acs_pkg::acs_mode_t mode, next_mode;
	logic mask_armed, next_mask_armed, mask_frame, next_mask_frame;
	logic next_conv_start, next_coding_q, next_range;
	logic [2:0] chan_addr, cur_chan, next_conv_chan;
	assign chan_addr = ctl[acs_pkg::CHAN_ADDR_MSB:acs_pkg::CHAN_ADDR_LSB];

	always_comb begin
		unique case (mode)
			acs_pkg::MODE_DIRECT: cur_chan = chan_addr;
			acs_pkg::MODE_CONSEC: cur_chan = pos[2:0];
			acs_pkg::MODE_MASK: cur_chan = (mask == 16'h0000) ? chan_addr : pos[2:0];
			default: cur_chan = chan_addr;
		endcase
	end

	always_comb begin
		next_ctl = ctl;
		next_mask = mask;
		next_pos = pos;
		next_mode = mode;
		next_mask_armed = mask_armed;
		next_mask_frame = mask_frame;
		next_conv_start = 1'h0;
		next_conv_chan = conv_chan;
		next_coding_q = coding_q;
		if (cs_fall) begin
			next_mask_frame = mask_armed;
			next_mask_armed = 1'h0;
			next_conv_start = 1'h1;
			next_conv_chan = cur_chan;
			next_coding_q = ctl[acs_pkg::CODING_BIT];
			if (mode == acs_pkg::MODE_CONSEC) begin
				next_pos = (pos[2:0] == chan_addr) ? 4'h0 : {1'h0, pos[2:0] + 3'h1};
			end else if (mode == acs_pkg::MODE_MASK) begin
				next_pos = mask_next(mask, pos);
			end
		end
		// a running sequence survives only a 1,0 write; host keeps to that
		if (ctl_done && !mask_frame && rx_next[acs_pkg::WR_EN_BIT]) begin
			next_ctl = rx_next[11:0];
			unique case ({rx_next[acs_pkg::AUTO_CYC_BIT], rx_next[acs_pkg::MASK_SEL_BIT]})
				2'h2: next_mode = mode;
				2'h1: begin
					next_mode = acs_pkg::MODE_DIRECT;
					next_mask_armed = 1'h1;
				end
				2'h3: begin
					next_mode = acs_pkg::MODE_CONSEC;
					next_pos = 4'h0;
				end
				2'h0: next_mode = acs_pkg::MODE_DIRECT;
			endcase
		end
		if (mask_done && mask_frame) begin
			next_mask = rx_next;
			next_mode = acs_pkg::MODE_MASK;
			next_pos = mask_next(rx_next, 4'hf);
			next_mask_frame = 1'h0;
		end
		next_range = next_ctl[acs_pkg::RANGE_BIT];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl <= acs_pkg::CTL_RESET;
			mask <= acs_pkg::MASK_RESET;
			pos <= 4'h0;
			mode <= acs_pkg::MODE_DIRECT;
			mask_armed <= 1'h0;
			mask_frame <= 1'h0;
			conv_start <= 1'h0;
			conv_chan <= 3'h0;
			coding_q <= 1'h0;
			range_span_ref <= 1'h0;
		end else begin
			ctl <= next_ctl;
			mask <= next_mask;
			pos <= next_pos;
			mode <= next_mode;
			mask_armed <= next_mask_armed;
			mask_frame <= next_mask_frame;
			conv_start <= next_conv_start;
			conv_chan <= next_conv_chan;
			coding_q <= next_coding_q;
			range_span_ref <= next_range;
		end
	end

	// ==========================================
	// axi4-lite slave
	logic [31:0] rd_word, wdata_q, next_wdata_q, next_rdata;
	logic [ADDR_W-1:0] awaddr_q, next_awaddr_q;
	logic aw_have, next_aw_have, w_have, next_w_have, wstrb0_q, next_wstrb0_q;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid, next_serial_en;
	logic [1:0] next_bresp, next_rresp;
	always_comb begin
		rd_word = 32'h00000000;
		if (araddr == ADDR_W'(acs_pkg::ADDR_STATUS)) begin
			rd_word[acs_pkg::ST_CHAN_LSB +: 3] = conv_chan;
			rd_word[acs_pkg::ST_POS_LSB +: 4] = pos;
			rd_word[acs_pkg::ST_MODE_LSB +: 2] = mode;
			rd_word[acs_pkg::ST_ARMED_BIT] = mask_armed;
			rd_word[acs_pkg::ST_LOADED_BIT] = tx_loaded;
		end else if (araddr == ADDR_W'(acs_pkg::ADDR_CTRL)) begin
			rd_word[11:0] = ctl;
		end else if (araddr == ADDR_W'(acs_pkg::ADDR_MASK)) begin
			rd_word[15:0] = mask;
		end else if (araddr == ADDR_W'(acs_pkg::ADDR_CFG)) begin
			rd_word[acs_pkg::CFG_EN_BIT] = serial_en;
		end
	end

	always_comb begin
		next_aw_have = aw_have;
		next_w_have = w_have;
		next_awaddr_q = awaddr_q;
		next_wdata_q = wdata_q;
		next_wstrb0_q = wstrb0_q;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		next_serial_en = serial_en;
		if (awvalid && awready) begin
			next_aw_have = 1'h1;
			next_awaddr_q = awaddr;
		end
		if (wvalid && wready) begin
			next_w_have = 1'h1;
			next_wdata_q = wdata;
			next_wstrb0_q = wstrb[0];
		end
		if (bvalid && bready) begin
			next_bvalid = 1'h0;
		end
		if (aw_have && w_have && !bvalid) begin
			next_aw_have = 1'h0;
			next_w_have = 1'h0;
			next_bvalid = 1'h1;
			next_bresp = is_mapped(awaddr_q) ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
			if (awaddr_q == ADDR_W'(acs_pkg::ADDR_CFG) && wstrb0_q) begin
				next_serial_en = wdata_q[acs_pkg::CFG_EN_BIT];
			end
		end
		next_awready = !next_aw_have && !next_bvalid;
		next_wready = !next_w_have && !next_bvalid;
		if (rvalid && rready) begin
			next_rvalid = 1'h0;
		end
		if (arvalid && arready) begin
			next_rvalid = 1'h1;
			next_rdata = rd_word;
			next_rresp = is_mapped(araddr) ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have <= 1'h0;
			w_have <= 1'h0;
			awaddr_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb0_q <= 1'h0;
			awready <= 1'h0;
			wready <= 1'h0;
			bvalid <= 1'h0;
			bresp <= acs_pkg::RESP_OKAY;
			arready <= 1'h0;
			rvalid <= 1'h0;
			rdata <= 32'h00000000;
			rresp <= acs_pkg::RESP_OKAY;
			serial_en <= acs_pkg::CFG_EN_RESET;
		end else begin
			aw_have <= next_aw_have;
			w_have <= next_w_have;
			awaddr_q <= next_awaddr_q;
			wdata_q <= next_wdata_q;
			wstrb0_q <= next_wstrb0_q;
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			serial_en <= next_serial_en;
		end
	end

	// ==========================================
	// assertions
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_DIRECT_CHAN: assert property (cs_fall && mode == acs_pkg::MODE_DIRECT |=>
		conv_start && conv_chan == $past(chan_addr)) else $error("direct channel wrong");
	AST_CODING: assert property (push && !coding_q |->
		push_word[11] != conv_data[11]) else $error("two's complement msb wrong");
	AST_RANGE: assert property (ctl_done && !mask_frame && rx_next[acs_pkg::WR_EN_BIT] |=>
		range_span_ref == $past(rx_next[acs_pkg::RANGE_BIT])) else $error("range output stale");
	AST_LEAD_ZERO: assert property (cs_fall ##1 !cs_fall [*2] |-> !dout) else $error("no zero");
	AST_MASK_CHAN: assert property (cs_fall && mode == acs_pkg::MODE_MASK && mask != 16'h0000 |=>
		conv_chan == $past(pos[2:0])) else $error("mask channel id wrong");
	AST_MASK_LOAD: assert property (mask_done && mask_frame |=> mode == acs_pkg::MODE_MASK &&
		mask == $past(rx_next) && pos == mask_next(mask, 4'hf)) else $error("mask load wrong");
	AST_ASCEND: assert property (cs_fall && mode == acs_pkg::MODE_MASK && !ctl_done |=>
		pos > $past(pos) || pos == mask_next(mask, 4'hf)) else $error("sequence not ascending");
	AST_KEEP: assert property (ctl_done && !mask_frame && rx_next[11] && rx_next[10] &&
		!rx_next[4] |=> $stable(mode)) else $error("1,0 write broke sequence");
	AST_END: assert property (ctl_done && !mask_frame && rx_next[11] && !rx_next[10] |=>
		mode == acs_pkg::MODE_DIRECT) else $error("sequence not ended");
	AST_CONSEC_WRAP: assert property (cs_fall && mode == acs_pkg::MODE_CONSEC &&
		pos[2:0] == chan_addr |=> pos == 4'h0) else $error("consecutive run no wrap");
	AST_NO_WRITE: assert property (ctl_done && !rx_next[acs_pkg::WR_EN_BIT] |=>
		ctl == $past(ctl)) else $error("control changed without write bit");
	AST_EMPTY_MASK: assert property (cs_fall && mode == acs_pkg::MODE_MASK && mask == 16'h0000 |=>
		conv_chan == $past(chan_addr)) else $error("empty mask fallback wrong");

	COV_MASK_LOAD: cover property (mask_done && mask_frame);
	COV_CONSEC: cover property (cs_fall && mode == acs_pkg::MODE_CONSEC && pos[2:0] == chan_addr);
	COV_FULL: cover property (conv_valid && !conv_ready);
endmodule

`default_nettype wire

// ===== dv/acs_host_model.sv
// host serial master and analog front end beside the sequencer
// assumes aclk at 25 MHz; sclk stays high for four aclk cycles and low for three
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
	// clock
	input wire logic aclk,
	// serial pins
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe,
	// analog front end
	input wire logic conv_start,
	input wire logic [2:0] conv_chan,
	input wire logic conv_ready,
	output logic conv_valid,
	output logic [11:0] conv_data,
	// answer delay and back-to-back offers
	input wire logic [3:0] slow,
	input wire logic flood
);
	logic [2:0] ch;
	int n;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
		conv_valid = 1'b0;
		conv_data = 12'h000;
	end
	// ==========================================
	// one 16-bit frame, msb first, din changes while sclk is high
	task automatic frame(input logic [15:0] tx, output logic [15:0] rx, output logic oe);
		int i;
		oe = 1'b0;
		@(posedge aclk);
		cs_n <= 1'b0;
		repeat (12) @(posedge aclk);
		for (i = 15; i >= 0; i--) begin
			din <= tx[i];
			repeat (3) @(posedge aclk);
			@(negedge aclk);
			rx[i] = dout;
			oe = oe | (dout_oe === 1'b1);
			@(posedge aclk);
			sclk <= 1'b0;
			repeat (3) @(posedge aclk);
			sclk <= 1'b1;
		end
		repeat (4) @(posedge aclk);
		cs_n <= 1'b1;
		din <= ~din;
		repeat (8) @(posedge aclk);
	endtask
	// ==========================================
	// front end: answers a start seen while idle, holds valid until taken or 400 cycles pass
	always begin
		@(negedge aclk);
		if (conv_start === 1'b1 || flood) begin
			ch = conv_chan;
			repeat (slow) @(posedge aclk);
			@(posedge aclk);
			conv_valid <= 1'b1;
			conv_data <= {ch, 9'h0c3};
			for (n = 0; n < 400; n++) begin
				@(negedge aclk);
				if (conv_ready === 1'b1) break;
			end
			@(posedge aclk);
			conv_valid <= 1'b0;
			conv_data <= ~conv_data;
		end
	end
endmodule
`default_nettype wire

// ===== dv/tb_acs_top.sv
// self-checking bench for the channel sequencer
// assumes the host model file is compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_acs_top;
	logic aclk, aresetn, cs_n, sclk, din, dout, dout_oe, conv_start, range_span_ref;
	logic conv_valid, conv_ready, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, oe, flood;
	logic [2:0] conv_chan;
	logic [11:0] conv_data;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb, slow;
	logic [1:0] bresp, rresp, r;
	logic [15:0] rx;
	int mismatches, n_compared, i;
	typedef struct {logic [2:0] c; logic rng; logic cod;} acs_row_t;
	acs_row_t rows [4] = '{'{3'h0, 1'b1, 1'b1}, '{3'h7, 1'b0, 1'b0}, '{3'h3, 1'b0, 1'b1},
		'{3'h5, 1'b1, 1'b0}};
	acs_top u_acs_top (.aclk(aclk), .aresetn(aresetn), .cs_n(cs_n), .sclk(sclk), .din(din),
		.dout(dout), .dout_oe(dout_oe), .conv_start(conv_start), .conv_chan(conv_chan),
		.range_span_ref(range_span_ref), .conv_valid(conv_valid), .conv_data(conv_data),
		.conv_ready(conv_ready), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	acs_host_model u_acs_host_model (.aclk(aclk), .cs_n(cs_n), .sclk(sclk), .din(din),
		.dout(dout), .dout_oe(dout_oe), .conv_start(conv_start), .conv_chan(conv_chan),
		.conv_ready(conv_ready), .conv_valid(conv_valid), .conv_data(conv_data),
		.slow(slow), .flood(flood));
	always #20 aclk = ~aclk;
	// ==========================================
	// reporting
	task automatic complete_run;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic timeout(input string what);
		mismatches++;
		$display("mismatch at %0t: %s timed out", $time, what);
		complete_run();
	endtask
	// ==========================================
	// control word, result word and frame helpers
	function automatic logic [15:0] ctl(logic seq, logic [2:0] a, logic sh, logic rg, logic cd);
		return {1'b1, seq, a, 2'h3, sh, 2'h0, rg, cd, 4'h0};
	endfunction
	function automatic logic [15:0] word(logic [2:0] c, logic cd);
		logic [11:0] raw;
		raw = {c, 9'h0c3};
		return {1'b0, c, cd ? raw : {~raw[11], raw[10:0]}};
	endfunction
	task automatic step(input logic [15:0] tx, input logic [2:0] c);
		u_acs_host_model.frame(tx, rx, oe);
		check("word", rx, word(c, 1'b1));
	endtask
	// ==========================================
	// axi4-lite master
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw, w, b;
		int n;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(negedge aclk);
			aw = awvalid && awready === 1'b1;
			w = wvalid && wready === 1'b1;
			b = bvalid === 1'b1;
			if (b) rs = bresp;
			@(posedge aclk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) begin
				bready <= 1'b0;
				return;
			end
		end
		timeout("write");
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ar;
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(negedge aclk);
			ar = arvalid && arready === 1'b1;
			if (rvalid === 1'b1) begin
				v = rdata;
				rs = rresp;
				@(posedge aclk);
				rready <= 1'b0;
				return;
			end
			@(posedge aclk);
			if (ar) arvalid <= 1'b0;
		end
		timeout("read");
	endtask
	// ==========================================
	// main sequence
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, flood} = 8'h00;
		{awaddr, araddr, wdata, wstrb, slow} = 56'h0;
		mismatches = 0;
		n_compared = 0;
		wstrb = 4'hf;
		repeat (20) @(posedge aclk);
		@(negedge aclk);
		check("reset outputs", {dout, dout_oe, conv_start, bvalid, rvalid}, 32'h0);
		@(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		axi_rd(acs_pkg::ADDR_CFG, d, r);
		check("cfg resp", r, acs_pkg::RESP_OKAY);
		check("cfg reset", d, 32'h1);
		axi_rd(acs_pkg::ADDR_CTRL, d, r);
		check("ctrl reset", d, {20'h0, acs_pkg::CTL_RESET});
		axi_rd(8'h10, d, r);
		check("unmapped resp", r, acs_pkg::RESP_SLVERR);
		check("unmapped read", d, 32'h0);
		axi_wr(8'h10, 32'h1, r);
		check("unmapped write", r, acs_pkg::RESP_SLVERR);
		axi_wr(acs_pkg::ADDR_CTRL, 32'hfff, r);
		axi_rd(acs_pkg::ADDR_CTRL, d, r);
		check("ctrl read only", d, 32'h0);
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			u_acs_host_model.frame(ctl(1'b0, rows[i].c, 1'b0, rows[i].rng, rows[i].cod), rx, oe);
			u_acs_host_model.frame(16'h0000, rx, oe);
			check("direct word", rx, word(rows[i].c, rows[i].cod));
			check("span", range_span_ref, rows[i].rng);
			check("chan", conv_chan, rows[i].c);
		end
		u_acs_host_model.frame({1'b0, 11'h7ff, 4'hf}, rx, oe);
		u_acs_host_model.frame(16'h0000, rx, oe);
		check("no write", rx, word(3'h5, 1'b0));
		axi_rd(acs_pkg::ADDR_CTRL, d, r);
		check("ctrl taken", d, {16'h0, ctl(1'b0, 3'h5, 1'b0, 1'b1, 1'b0) >> 4});
		$display("test direct done");
		slow <= 4'h3;
		u_acs_host_model.frame(ctl(1'b0, 3'h2, 1'b1, 1'b0, 1'b1), rx, oe);
		check("word", rx, word(3'h5, 1'b0));
		step(16'h4802, 3'h2);
		axi_rd(acs_pkg::ADDR_MASK, d, r);
		check("mask", d, 32'h4802);
		step(16'h0000, 3'h1);
		step(ctl(1'b1, 3'h0, 1'b0, 1'b0, 1'b1), 3'h4);
		step(16'h0000, 3'h6);
		step(16'h0000, 3'h1);
		step(ctl(1'b0, 3'h3, 1'b0, 1'b0, 1'b1), 3'h4);
		step(16'h0000, 3'h3);
		$display("test mask sequence done");
		step(ctl(1'b1, 3'h2, 1'b1, 1'b0, 1'b1), 3'h3);
		step(16'h0000, 3'h0);
		step(16'h0000, 3'h1);
		step(16'h0000, 3'h2);
		step(ctl(1'b1, 3'h2, 1'b0, 1'b0, 1'b1), 3'h0);
		step(ctl(1'b0, 3'h5, 1'b1, 1'b0, 1'b1), 3'h1);
		step(16'h0000, 3'h5);
		step(16'h0000, 3'h5);
		$display("test consecutive and empty mask done");
		slow <= 4'h0;
		axi_wr(acs_pkg::ADDR_CFG, 32'h0, r);
		u_acs_host_model.frame(16'h0000, rx, oe);
		check("disabled frame", oe, 1'b0);
		axi_wr(acs_pkg::ADDR_CFG, 32'h1, r);
		u_acs_host_model.frame(16'h0000, rx, oe);
		check("enabled frame", oe, 1'b1);
		$display("test serial enable done");
		flood <= 1'b1;
		for (i = 0; i < 100 && conv_ready !== 1'b0; i++) @(negedge aclk);
		if (i == 100) timeout("buffer fill");
		repeat (20) @(negedge aclk);
		check("full refuses", conv_ready, 1'b0);
		@(posedge aclk);
		flood <= 1'b0;
		fork
			u_acs_host_model.frame(16'h0000, rx, oe);
			begin
				for (i = 0; i < 100 && conv_ready !== 1'b1; i++) @(negedge aclk);
				check("drained", conv_ready, 1'b1);
			end
		join
		check("buffered word", rx, word(3'h5, 1'b1));
		$display("test buffer done");
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		@(negedge aclk);
		check("reset again", {dout, dout_oe, conv_start, conv_ready, bvalid, rvalid}, 32'h0);
		@(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		axi_rd(acs_pkg::ADDR_STATUS, d, r);
		check("status resp", r, acs_pkg::RESP_OKAY);
		check("status reset", d, 32'h0);
		axi_rd(acs_pkg::ADDR_MASK, d, r);
		check("mask reset", d, {16'h0, acs_pkg::MASK_RESET});
		$display("test mid-run reset done");
		complete_run();
	end
endmodule
`default_nettype wire
